// *** rtl/ars_top.v ***
`include "ars_defs.vh"
`default_nettype none

// Function
// RL1 - two flip-flops encode ten, hundred, thousand, overload
// RL2 - range changes only on a transfer pulse; code also changes it on a software trigger or a manual write
// RL3 - qualifiers coincide with pulse; update at falling edge
// RL4 - 101 holds; 011 steps one range up
// RL5 - 100 steps down; overload drops to hundred
// RL6 - counter asks down below 100, up above 1400
// RL7 - one measurement gives exactly one transfer pulse
// RL8 - decoder drives relays and decimal point
// RL9 - unlisted qualifier patterns leave range unchanged
module ars_top
#(
  parameter CNT_W = 8
)
(
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        transferPulse,
  input  wire        stepUpQual,
  input  wire        stepDownQual,
  input  wire        holdQual,
  output reg         rangeStateA,
  output reg         rangeStateB,
  output reg         driverA,
  output reg         driverB,
  output reg         driverC,
  output reg         driverD,
  output reg  [2:0]  decimalPoint,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  reg              transferPrev;
  reg  [2:0]       qualHeld;
  reg  [1:0]       ctrl;
  reg  [CNT_W-1:0] transferCount;
  reg              awHeld;
  reg              wHeld;
  reg  [3:0]       wAddr;
  reg  [31:0]      wData;
  reg  [3:0]       wStrb;
  wire [2:0]       qualLive;
  wire [1:0]       rangeNow;
  wire             transferFall;
  wire             swTrig;
  wire [3:0]       drvNext;
  wire [2:0]       dpNext;
  wire             doWrite;
  wire [31:0]      statusWord;
  reg  [1:0]       next_range;

  // selects next range for a qualifier pattern
  function [1:0] stepRange;
    input [1:0] cur;
    input [2:0] qual;
    begin
      stepRange = cur; // RL9
      if (qual == `ARS_QUAL_UP)
      begin
        case (cur)
          `ARS_RANGE_TEN:     stepRange = `ARS_RANGE_HUNDRED; // RL4
          `ARS_RANGE_HUNDRED: stepRange = `ARS_RANGE_THOUS;
          `ARS_RANGE_THOUS:   stepRange = `ARS_RANGE_OVL;
          default:            stepRange = cur;
        endcase
      end
      else if (qual == `ARS_QUAL_DOWN)
      begin
        case (cur)
          `ARS_RANGE_OVL:     stepRange = `ARS_RANGE_HUNDRED; // RL5
          `ARS_RANGE_THOUS:   stepRange = `ARS_RANGE_HUNDRED;
          `ARS_RANGE_HUNDRED: stepRange = `ARS_RANGE_TEN;
          default:            stepRange = cur;
        endcase
      end
      else if (qual == `ARS_QUAL_HOLD)
      begin
        stepRange = cur; // RL4
      end
    end
  endfunction

  assign qualLive     = {stepUpQual, stepDownQual, holdQual};
  assign rangeNow     = {rangeStateB, rangeStateA};
  assign transferFall = transferPrev & ~transferPulse; // RL3
  assign swTrig       = doWrite & (wAddr == `ARS_OFF_CTRL) & wStrb[0]
                        & wData[`ARS_CTRL_SWTRIG];
  assign doWrite      = awHeld & wHeld & ~s_axi_bvalid;
  // count sits at bit 16, gap 15..9 reads zero
  assign statusWord   = {{(16-CNT_W){1'b0}}, transferCount, 7'h0,
                         driverD, driverC, driverB, driverA,
                         qualHeld, rangeStateB, rangeStateA};

  ars_range_decoder u_dec
  (
    .rangeState   (next_range),
    .driver       (drvNext),
    .decimalPoint (dpNext)
  );

  // qualifiers are taken while the pulse is high, so the values that
  // coincided with the pulse survive a late change at its trailing edge
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      transferPrev <= 1'b0;
      qualHeld     <= 3'h0;
    end
    else
    begin
      transferPrev <= transferPulse;
      if (transferPulse)
      begin
        qualHeld <= qualLive; // RL3
      end
    end
  end

  always @*
  begin
    next_range = rangeNow; // RL2
    if (ctrl[`ARS_CTRL_AUTO])
    begin
      if (transferFall)
      begin
        next_range = stepRange(rangeNow, qualHeld); // RL3
      end
      else if (swTrig)
      begin
        next_range = stepRange(rangeNow, qualLive);
      end
    end
    else if (doWrite && (wAddr == `ARS_OFF_RANGE) && wStrb[0])
    begin
      // manual selection only while automatic stepping is off
      next_range = wData[1:0];
    end
  end

  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rangeStateA   <= 1'b0;
      rangeStateB   <= 1'b0;
      driverA       <= 1'b1;
      driverB       <= 1'b0;
      driverC       <= 1'b0;
      driverD       <= 1'b0;
      decimalPoint  <= `ARS_DP_TEN;
      transferCount <= {CNT_W{1'b0}};
    end
    else
    begin
      rangeStateA  <= next_range[0]; // RL1
      rangeStateB  <= next_range[1]; // RL1
      driverA      <= drvNext[0]; // RL8
      driverB      <= drvNext[1];
      driverC      <= drvNext[2];
      driverD      <= drvNext[3];
      decimalPoint <= dpNext; // RL8
      if (ctrl[`ARS_CTRL_AUTO] && (transferFall || swTrig))
      begin
        // wraps; counts transfers and software triggers while automatic stepping is on
        transferCount <= transferCount + {{(CNT_W-1){1'b0}}, 1'b1}; // RL7
      end
    end
  end

  // write side: address and data taken in either order
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      wAddr         <= 4'h0;
      wData         <= 32'h0;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ARS_RESP_OKAY;
      ctrl          <= `ARS_CTRL_RESET;
    end
    else
    begin
      s_axi_awready <= ~awHeld & ~s_axi_awready & ~s_axi_bvalid;
      s_axi_wready  <= ~wHeld & ~s_axi_wready & ~s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld        <= 1'b1;
        wAddr         <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld        <= 1'b1;
        wData        <= s_axi_wdata;
        wStrb        <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `ARS_RESP_OKAY;
        case (wAddr)
          `ARS_OFF_CTRL:
          begin
            if (wStrb[0])
            begin
              ctrl[`ARS_CTRL_AUTO] <= wData[`ARS_CTRL_AUTO];
            end
          end
          `ARS_OFF_RANGE:  s_axi_bresp <= `ARS_RESP_OKAY;
          `ARS_OFF_STATUS: s_axi_bresp <= `ARS_RESP_OKAY;
          default:         s_axi_bresp <= `ARS_RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      // trigger bit always reads back zero
      ctrl[`ARS_CTRL_SWTRIG] <= 1'b0;
    end
  end

  // read side: one cycle from address to data
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `ARS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `ARS_RESP_OKAY;
        case (s_axi_araddr)
          `ARS_OFF_CTRL:   s_axi_rdata <= {30'h0, ctrl};
          `ARS_OFF_RANGE:  s_axi_rdata <= {30'h0, rangeStateB, rangeStateA};
          `ARS_OFF_STATUS: s_axi_rdata <= statusWord;
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ARS_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ars_top

`default_nettype wire

// *** rtl/ars_defs.vh ***
`ifndef ARS_DEFS_VH
`define ARS_DEFS_VH

// register byte offsets
`define ARS_OFF_CTRL      4'h0
`define ARS_OFF_RANGE     4'h4
`define ARS_OFF_STATUS    4'h8

// control fields
`define ARS_CTRL_AUTO     0
`define ARS_CTRL_SWTRIG   1
`define ARS_CTRL_RESET    2'h1

// range codes, written {range_state_b, range_state_a}
`define ARS_RANGE_TEN     2'h0
`define ARS_RANGE_HUNDRED 2'h1
`define ARS_RANGE_THOUS   2'h2
`define ARS_RANGE_OVL     2'h3

// qualifier patterns {first, second, third}
`define ARS_QUAL_HOLD     3'h5
`define ARS_QUAL_UP       3'h3
`define ARS_QUAL_DOWN     3'h4

// decimal point one-hot positions
`define ARS_DP_TEN        3'h1
`define ARS_DP_HUNDRED    3'h2
`define ARS_DP_THOUS      3'h4

// status field positions
`define ARS_ST_RANGE_LSB  0
`define ARS_ST_QUAL_LSB   2
`define ARS_ST_DRV_LSB    5
`define ARS_ST_CNT_LSB    16

// axi responses
`define ARS_RESP_OKAY     2'h0
`define ARS_RESP_SLVERR   2'h2

`endif

// *** rtl/ars_range_decoder.v ***
`include "ars_defs.vh"
`default_nettype none

module ars_range_decoder
(
  input  wire [1:0] rangeState,
  output reg  [3:0] driver,
  output reg  [2:0] decimalPoint
);

  // driver bits {D, C, B, A}
  always @*
  begin
    driver       = 4'h1;
    decimalPoint = `ARS_DP_TEN;
    case (rangeState)
      `ARS_RANGE_TEN:
      begin
        driver       = 4'h1; // RL1
        decimalPoint = `ARS_DP_TEN; // RL8
      end
      `ARS_RANGE_HUNDRED:
      begin
        driver       = 4'h2; // RL1
        decimalPoint = `ARS_DP_HUNDRED; // RL8
      end
      `ARS_RANGE_THOUS:
      begin
        driver       = 4'h4; // RL1
        decimalPoint = `ARS_DP_THOUS; // RL8
      end
      `ARS_RANGE_OVL:
      begin
        driver       = 4'hc; // RL1
        decimalPoint = `ARS_DP_THOUS; // RL8
      end
      default:
      begin
        driver       = 4'h1;
        decimalPoint = `ARS_DP_TEN;
      end
    endcase
  end

endmodule // ars_range_decoder

`default_nettype wire

// *** verification/ars_top_asserts.sv ***
`include "ars_defs.vh"
`default_nettype none
module ars_top_asserts
(
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       transferPulse,
  input wire logic       stepUpQual,
  input wire logic       stepDownQual,
  input wire logic       holdQual,
  input wire logic       rangeStateA,
  input wire logic       rangeStateB,
  input wire logic       driverA,
  input wire logic       driverB,
  input wire logic       driverC,
  input wire logic       driverD,
  input wire logic [2:0] decimalPoint,
  input wire logic       s_axi_bvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  wire [1:0] rng = {rangeStateB, rangeStateA};
  wire [2:0] qual = {stepUpQual, stepDownQual, holdQual};
  wire [3:0] drv = {driverD, driverC, driverB, driverA};
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // saturates: up from overload and down from ten hold
  function automatic logic [1:0] stepOf(input logic [1:0] r, input logic [2:0] q);
    if (q == `ARS_QUAL_UP)
      return (r == `ARS_RANGE_OVL) ? r : r + 2'h1;
    if (q == `ARS_QUAL_DOWN)
      return (r == `ARS_RANGE_TEN) ? r : {1'b0, r != `ARS_RANGE_HUNDRED};
    return r;
  endfunction
  a_step_result: assert property ($fell(transferPulse) |=>
    rng == stepOf($past(rng), $past(qual, 2))) else $error("wrong range after transfer");
  a_hold_between: assert property (!$fell(transferPulse) |=>
    $rose(s_axi_bvalid) || $stable(rng)) else $error("range moved without transfer");
  a_no_early: assert property (transferPulse |=> $stable(rng))
    else $error("range moved while pulse high");
  a_down_hundred: assert property ($fell(transferPulse) && rng[1] &&
    $past(qual) == `ARS_QUAL_DOWN |=> rng == `ARS_RANGE_HUNDRED) else $error("no drop to hundred");
  a_hold_pattern: assert property ($fell(transferPulse) &&
    $past(qual) == `ARS_QUAL_HOLD |=> $stable(rng)) else $error("hold pattern moved range");
  a_drive_decode: assert property (drv == (rng == 2'h0 ? 4'h1 : rng == 2'h1 ? 4'h2 :
    rng == 2'h2 ? 4'h4 : 4'hc)) else $error("relay drive mismatch");
  a_point_decode: assert property (decimalPoint == (rng == 2'h0 ? 3'h1 :
    rng == 2'h1 ? 3'h2 : 3'h4)) else $error("decimal point mismatch");
  a_reset_ten: assert property ($rose(arst_n) |-> rng == 2'h0 && drv == 4'h1)
    else $error("not ten range after reset");
  c_up: cover property ($fell(transferPulse) && $past(qual) == `ARS_QUAL_UP);
  c_down: cover property ($fell(transferPulse) && $past(qual) == `ARS_QUAL_DOWN);
  c_hold: cover property ($fell(transferPulse) && $past(qual) == `ARS_QUAL_HOLD);
endmodule // ars_top_asserts
bind ars_top ars_top_asserts chk_u (.core_clk, .arst_n, .transferPulse, .stepUpQual,
  .stepDownQual, .holdQual, .rangeStateA, .rangeStateB, .driverA, .driverB, .driverC,
  .driverD, .decimalPoint, .s_axi_bvalid);
`default_nettype wire

// *** verification/ars_count_model.sv ***
`include "ars_defs.vh"
`default_nettype none
module ars_count_model
(
  input  wire logic core_clk,
  output var logic  transferPulse,
  output var logic  stepUpQual,
  output var logic  stepDownQual,
  output var logic  holdQual
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {stepUpQual, stepDownQual, holdQual, transferPulse} = 4'h0;
  task automatic pulse(input logic [2:0] q);
    @(posedge core_clk);
    {stepUpQual, stepDownQual, holdQual} <= q;
    transferPulse <= 1'b1;
    @(posedge core_clk);
    transferPulse <= 1'b0;
    @(posedge core_clk);
    // lines wander between transfers, the selector must ignore them
    {stepUpQual, stepDownQual, holdQual} <= ~q;
  endtask
  // sets the live lines without a transfer, for the software trigger
  task automatic set_lines(input logic [2:0] q);
    @(posedge core_clk);
    {stepUpQual, stepDownQual, holdQual} <= q;
  endtask
  task automatic measure(input int count);
    if (count < 100)
      pulse(`ARS_QUAL_DOWN);
    else if (count > 1400)
      pulse(`ARS_QUAL_UP);
    else
      pulse(`ARS_QUAL_HOLD);
  endtask
endmodule // ars_count_model
`default_nettype wire

// *** verification/tb_autorange_state_selector.sv ***
`include "ars_defs.vh"
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_autorange_state_selector;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, arst_n, transferPulse, stepUpQual, stepDownQual, holdQual;
  logic rangeStateA, rangeStateB, driverA, driverB, driverC, driverD;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] decimalPoint;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  int n_fail, checked;
  // {qualifiers, range after transfer}; unlisted pattern 000 in the middle, the other unlisted patterns at the end
  logic [4:0] steps [16] = '{5'h0d, 5'h0e, 5'h0f, 5'h0f, 5'h17, 5'h11, 5'h0e, 5'h11,
    5'h10, 5'h10, 5'h00, 5'h0d, 5'h1d, 5'h19, 5'h09, 5'h05};
  ars_top dut_u (.*);
  ars_count_model far_u (.core_clk, .transferPulse, .stepUpQual, .stepDownQual, .holdQual);
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge core_clk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk_range(input logic [1:0] r);
    `CHK({rangeStateB, rangeStateA}, r)
    `CHK({driverD, driverC, driverB, driverA}, r == 0 ? 4'h1 : r == 1 ? 4'h2 : r == 2 ? 4'h4 : 4'hc)
    `CHK(decimalPoint, r == 0 ? 3'h1 : r == 1 ? 3'h2 : 3'h4)
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial
  begin
    #100000;
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    #1 chk_range(2'h0);
    rd_reg(`ARS_OFF_CTRL);
    `CHK(rd, 32'h1)
    rd_reg(4'hc);
    `CHK({rsp, rd}, {`ARS_RESP_SLVERR, 32'h0})
    foreach (steps[i])
    begin
      far_u.pulse(steps[i][4:2]);
      #1 chk_range(steps[i][1:0]);
    end
    far_u.measure(2000);
    #1 chk_range(2'h2);
    far_u.measure(50);
    #1 chk_range(2'h1);
    far_u.measure(500);
    #1 chk_range(2'h1);
    wr(`ARS_OFF_RANGE, 32'h3);
    `CHK(rsp, `ARS_RESP_OKAY)
    #1 chk_range(2'h1);
    rd_reg(`ARS_OFF_STATUS);
    `CHK(rd, 32'h00130055)
    // manual selection with automatic stepping off
    wr(`ARS_OFF_CTRL, 32'h0);
    `CHK(rsp, `ARS_RESP_OKAY)
    wr(`ARS_OFF_RANGE, 32'h3);
    #1 chk_range(2'h3);
    rd_reg(`ARS_OFF_RANGE);
    `CHK(rd, 32'h3)
    // software trigger steps on the live lines
    wr(`ARS_OFF_CTRL, 32'h1);
    far_u.set_lines(`ARS_QUAL_DOWN);
    wr(`ARS_OFF_CTRL, 32'h3);
    `CHK(rsp, `ARS_RESP_OKAY)
    #1 chk_range(2'h1);
    rd_reg(`ARS_OFF_CTRL);
    `CHK(rd, 32'h1)
    wr(4'hc, 32'h0);
    `CHK(rsp, `ARS_RESP_SLVERR)
    rd_reg(`ARS_OFF_STATUS);
    `CHK(rd, 32'h00140055)
    report_and_stop();
  end
endmodule // tb_autorange_state_selector
`default_nettype wire
